/* File: common/pmbs_defines.vh */
`ifndef PMBS_DEFINES_VH
`define PMBS_DEFINES_VH

// Mux select codes per pin (2 bits each)
`define PMBS_SEL_FN1       2'h0
`define PMBS_SEL_FN2       2'h1
`define PMBS_SEL_FN3       2'h2
`define PMBS_SEL_W         2

// Fast I/O port
`define PMBS_IO_W          16
`define PMBS_PIN_N         10

// Fast I/O operation codes
`define PMBS_OP_WRITE      2'h0
`define PMBS_OP_SET        2'h1
`define PMBS_OP_CLEAR      2'h2
`define PMBS_OP_TOGGLE     2'h3

// External interrupt trigger modes
`define PMBS_TRIG_RISE     2'h0
`define PMBS_TRIG_FALL     2'h1
`define PMBS_TRIG_HIGH     2'h2
`define PMBS_TRIG_LOW      2'h3

// External interrupt priority level
`define PMBS_IRQ_LEVEL     3'h7

// Boot strap sampling: cycles after reset release
`define PMBS_STRAP_DELAY   4'h2

`endif

/* File: hw/pmbs_fast_io.v */
`timescale 1ns/1ns
`include "pmbs_defines.vh"

// Fast general purpose I/O register with single-cycle write/set/clear/toggle
module pmbs_fast_io #(
	parameter W = `PMBS_IO_W
) (
	// Clock and reset
	input  wire         clk,
	input  wire         reset,
	// CPU access
	input  wire         op_valid,
	input  wire [1:0]   op_code,
	input  wire [W-1:0] op_data,
	// Port value
	output reg  [W-1:0] port_reg
);

	reg [W-1:0] port_next;

	always @* begin
		port_next = port_reg;
		if (op_valid) begin
			case (op_code)
				`PMBS_OP_WRITE:  port_next = op_data;
				`PMBS_OP_SET:    port_next = port_reg | op_data;
				`PMBS_OP_CLEAR:  port_next = port_reg & ~op_data;
				`PMBS_OP_TOGGLE: port_next = port_reg ^ op_data;
				default:         port_next = port_reg;
			endcase
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			port_reg <= {W{1'b0}};
		end else begin
			port_reg <= port_next;
		end
	end

endmodule

/* File: hw/pmbs_pin_mux.v */
`timescale 1ns/1ns
`include "pmbs_defines.vh"

// Contract
// - After reset every multiplexed pin takes its first function.
// - Ten pins shared between fast I/O bits and alternates, one driver each.
// - Fast I/O port is 16 bits, write/set/clear/toggle, low ten bits reach pins.
// - Debug pin sampled at start-up: high runs normally, low enters debug.
// - In debug state the debug pin is a bidirectional single-wire port.
// - Select pin level at start-up: low picks SPI slave, high I2C slave.
// - Reset pin open-drain with pull-up, input after power-up, optionally bidirectional.
// - Device may drive reset pin low when enabled, never as power-on reset.
// - External interrupt wakes from deep sleep; rise, fall, high or low trigger.
// - External interrupt is delivered at priority level seven.
// - Slave-port interrupt output flags host when a response is ready.
// - ADC converts pos minus neg analog pins at accelerometer sample rate.
// - Delay-block outputs drive their pins when selected.
// - Timer channels zero and one reach their pins as bidirectional I/O.
// - Host control via slave SPI (clock, in, out, select) or slave I2C.
// - Slave interfaces stay routed at all times, deep sleep included, except SPI select, routed only when pin 3 takes its third function.
module pmbs_pin_mux #(
	parameter IO_W  = `PMBS_IO_W,
	parameter PIN_N = `PMBS_PIN_N
) (
	// Clock and reset
	input  wire              clk,
	input  wire              reset,
	// Mux selects, two bits per pin, pin n at [2n+1:2n]
	input  wire [2*PIN_N-1:0] mux_sel,
	// Fast I/O CPU access
	input  wire              io_op_valid,
	input  wire [1:0]        io_op_code,
	input  wire [IO_W-1:0]   io_op_data,
	input  wire [PIN_N-1:0]  io_dir,
	output reg  [IO_W-1:0]   io_read_reg,
	// Pads
	input  wire [PIN_N-1:0]  pad_in,
	output reg  [PIN_N-1:0]  pad_out_reg,
	output reg  [PIN_N-1:0]  pad_oe_reg,
	// Reset pin (open drain)
	input  wire              reset_n_pin_in,
	output reg               reset_n_pin_out_reg,
	output reg               reset_n_pin_oe_reg,
	input  wire              reset_pin_bidir_en,
	input  wire              ext_reset_req,
	output reg               ext_reset_detect_reg,
	// Boot straps
	output reg               strap_done_reg,
	output reg               background_debug_state_reg,
	output reg               slave_spi_mode_reg,
	// Debug single wire
	input  wire              dbg_out,
	input  wire              dbg_oe,
	output reg               dbg_in_reg,
	// Slave I2C (open drain)
	input  wire              slave_i2c_clock_oe,
	input  wire              slave_i2c_data_oe,
	output reg               slave_i2c_clock_reg,
	output reg               slave_i2c_data_reg,
	// Slave SPI
	input  wire              spi_data_out,
	input  wire              spi_data_out_en,
	output reg               spi_clock_reg,
	output reg               spi_data_in_reg,
	output reg               spi_select_n_reg,
	// Master I2C (open drain)
	input  wire              master_i2c_clock_oe,
	input  wire              master_i2c_data_oe,
	output reg               master_i2c_clock_reg,
	output reg               master_i2c_data_reg,
	// External interrupt
	input  wire [1:0]        ext_irq_trigger,
	input  wire              ext_irq_clear,
	output reg               ext_irq_reg,
	output reg  [2:0]        ext_irq_level_reg,
	output reg               wake_reg,
	// Slave-port interrupt, delay block, timer
	input  wire              response_ready,
	input  wire              delay_block_out_a,
	input  wire              delay_block_out_b,
	input  wire              timer_channel_zero_out,
	input  wire              timer_channel_zero_oe,
	input  wire              timer_channel_one_out,
	input  wire              timer_channel_one_oe,
	output reg               timer_channel_zero_in_reg,
	output reg               timer_channel_one_in_reg,
	// Analog input routing to ADC
	output reg               adc_diff_en_reg,
	input  wire              sample_strobe,
	output reg               adc_convert_reg
);

	// ************************************************
	// Helpers
	// ************************************************
	function [1:0] sel_of;
		input [2*PIN_N-1:0] s;
		input integer       n;
		begin
			sel_of = s[2*n +: 2];
		end
	endfunction

	wire [IO_W-1:0] fast_io_port;
	reg  [PIN_N-1:0] out_next;
	reg  [PIN_N-1:0] oe_next;
	reg  [3:0]       strap_cnt_reg;
	reg              irq_in_d_reg;
	reg              irq_hit;
	wire [1:0]       s4;
	integer          i;

	pmbs_fast_io #(.W(IO_W)) u_fast_io (
		.clk      (clk),
		.reset    (reset),
		.op_valid (io_op_valid),
		.op_code  (io_op_code),
		.op_data  (io_op_data),
		.port_reg (fast_io_port)
	);

	assign s4 = sel_of(mux_sel, 4);

	// ************************************************
	// Pad output mux
	// ************************************************
	// Every select code not listed leaves the pin undriven
	always @* begin
		for (i = 0; i < PIN_N; i = i + 1) begin
			out_next[i] = fast_io_port[i];
			oe_next[i]  = 1'b0;
		end
		// Pin 0 and 1: slave I2C clock/data, fast I/O, SPI clock/data in
		if (sel_of(mux_sel, 0) == `PMBS_SEL_FN1) begin
			out_next[0] = 1'b0;
			oe_next[0]  = slave_i2c_clock_oe;
		end else if (sel_of(mux_sel, 0) == `PMBS_SEL_FN2) begin
			oe_next[0]  = io_dir[0];
		end
		if (sel_of(mux_sel, 1) == `PMBS_SEL_FN1) begin
			out_next[1] = 1'b0;
			oe_next[1]  = slave_i2c_data_oe;
		end else if (sel_of(mux_sel, 1) == `PMBS_SEL_FN2) begin
			oe_next[1]  = io_dir[1];
		end
		// Pin 2: fast I/O, master I2C clock, SPI data out
		case (sel_of(mux_sel, 2))
			`PMBS_SEL_FN1: oe_next[2] = io_dir[2];
			`PMBS_SEL_FN2: begin
				out_next[2] = 1'b0;
				oe_next[2]  = master_i2c_clock_oe;
			end
			`PMBS_SEL_FN3: begin
				out_next[2] = spi_data_out;
				oe_next[2]  = spi_data_out_en;
			end
			default: oe_next[2] = 1'b0;
		endcase
		// Pin 3: fast I/O, master I2C data, SPI select (input)
		case (sel_of(mux_sel, 3))
			`PMBS_SEL_FN1: oe_next[3] = io_dir[3];
			`PMBS_SEL_FN2: begin
				out_next[3] = 1'b0;
				oe_next[3]  = master_i2c_data_oe;
			end
			default: oe_next[3] = 1'b0;
		endcase
		// Pin 4: fast I/O or interrupt input
		if (s4 == `PMBS_SEL_FN1) begin
			oe_next[4] = io_dir[4];
		end
		// Pin 5: fast I/O, delay block A, slave-port interrupt
		case (sel_of(mux_sel, 5))
			`PMBS_SEL_FN1: oe_next[5] = io_dir[5];
			`PMBS_SEL_FN2: begin
				out_next[5] = delay_block_out_a;
				oe_next[5]  = 1'b1;
			end
			`PMBS_SEL_FN3: begin
				out_next[5] = response_ready;
				oe_next[5]  = 1'b1;
			end
			default: oe_next[5] = 1'b0;
		endcase
		// Pin 6 and 7: fast I/O, analog input, timer channel
		case (sel_of(mux_sel, 6))
			`PMBS_SEL_FN1: oe_next[6] = io_dir[6];
			`PMBS_SEL_FN3: begin
				out_next[6] = timer_channel_zero_out;
				oe_next[6]  = timer_channel_zero_oe;
			end
			default: oe_next[6] = 1'b0;
		endcase
		case (sel_of(mux_sel, 7))
			`PMBS_SEL_FN1: oe_next[7] = io_dir[7];
			`PMBS_SEL_FN3: begin
				out_next[7] = timer_channel_one_out;
				oe_next[7]  = timer_channel_one_oe;
			end
			default: oe_next[7] = 1'b0;
		endcase
		// Pin 8: fast I/O or delay block B
		case (sel_of(mux_sel, 8))
			`PMBS_SEL_FN1: oe_next[8] = io_dir[8];
			`PMBS_SEL_FN2: begin
				out_next[8] = delay_block_out_b;
				oe_next[8]  = 1'b1;
			end
			default: oe_next[8] = 1'b0;
		endcase
		// Pin 9: debug port first; debug state overrides the mux
		if (background_debug_state_reg) begin
			out_next[9] = dbg_out;
			oe_next[9]  = dbg_oe;
		end else if (sel_of(mux_sel, 9) == `PMBS_SEL_FN2) begin
			oe_next[9]  = io_dir[9];
		end
		// Hold all pads released until straps are caught
		if (!strap_done_reg) begin
			oe_next = {PIN_N{1'b0}};
		end
	end

	// ************************************************
	// Pads, straps and inputs
	// ************************************************
	always @(posedge clk) begin
		if (reset) begin
			pad_out_reg                <= {PIN_N{1'b0}};
			pad_oe_reg                 <= {PIN_N{1'b0}};
			io_read_reg                <= {IO_W{1'b0}};
			strap_cnt_reg              <= 4'h0;
			strap_done_reg             <= 1'b0;
			background_debug_state_reg <= 1'b0;
			slave_spi_mode_reg         <= 1'b0;
			dbg_in_reg                 <= 1'b1;
			slave_i2c_clock_reg        <= 1'b1;
			slave_i2c_data_reg         <= 1'b1;
			spi_clock_reg              <= 1'b0;
			spi_data_in_reg            <= 1'b0;
			spi_select_n_reg           <= 1'b1;
			master_i2c_clock_reg       <= 1'b1;
			master_i2c_data_reg        <= 1'b1;
			timer_channel_zero_in_reg  <= 1'b0;
			timer_channel_one_in_reg   <= 1'b0;
			adc_diff_en_reg            <= 1'b0;
			adc_convert_reg            <= 1'b0;
		end else begin
			pad_out_reg <= out_next;
			pad_oe_reg  <= oe_next;
			io_read_reg <= {fast_io_port[IO_W-1:PIN_N], pad_in};
			// Straps sampled once, a few cycles after release
			if (!strap_done_reg) begin
				if (strap_cnt_reg == `PMBS_STRAP_DELAY) begin
					strap_done_reg             <= 1'b1;
					background_debug_state_reg <= ~pad_in[9];
					slave_spi_mode_reg         <= ~pad_in[3];
				end else begin
					strap_cnt_reg <= strap_cnt_reg + 4'h1;
				end
			end
			dbg_in_reg <= pad_in[9];
			// Slave ports always routed, independent of sleep state, except SPI select, routed only when pin 3 takes its third function
			slave_i2c_clock_reg  <= pad_in[0];
			slave_i2c_data_reg   <= pad_in[1];
			spi_clock_reg        <= pad_in[0];
			spi_data_in_reg      <= pad_in[1];
			spi_select_n_reg     <= (sel_of(mux_sel, 3) == `PMBS_SEL_FN3) ? pad_in[3] : 1'b1;
			master_i2c_clock_reg <= pad_in[2];
			master_i2c_data_reg  <= pad_in[3];
			timer_channel_zero_in_reg <= pad_in[6];
			timer_channel_one_in_reg  <= pad_in[7];
			adc_diff_en_reg <= (sel_of(mux_sel, 6) == `PMBS_SEL_FN2) &&
				(sel_of(mux_sel, 7) == `PMBS_SEL_FN2);
			adc_convert_reg <= sample_strobe && adc_diff_en_reg;
		end
	end

	// ************************************************
	// Reset pin
	// ************************************************
	// Power-on reset keeps drive off; input only until enabled
	always @(posedge clk) begin
		if (reset) begin
			reset_n_pin_out_reg  <= 1'b0;
			reset_n_pin_oe_reg   <= 1'b0;
			ext_reset_detect_reg <= 1'b0;
		end else begin
			reset_n_pin_out_reg  <= 1'b0;
			reset_n_pin_oe_reg   <= reset_pin_bidir_en && ext_reset_req;
			// Own drive is not reported as an outside reset
			ext_reset_detect_reg <= !reset_n_pin_in && !reset_n_pin_oe_reg;
		end
	end

	// ************************************************
	// External interrupt
	// ************************************************
	always @* begin
		case (ext_irq_trigger)
			`PMBS_TRIG_RISE: irq_hit = pad_in[4] && !irq_in_d_reg;
			`PMBS_TRIG_FALL: irq_hit = !pad_in[4] && irq_in_d_reg;
			`PMBS_TRIG_HIGH: irq_hit = pad_in[4];
			`PMBS_TRIG_LOW:  irq_hit = !pad_in[4];
			default:         irq_hit = 1'b0;
		endcase
		if (s4 != `PMBS_SEL_FN2) begin
			irq_hit = 1'b0;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			irq_in_d_reg      <= 1'b0;
			ext_irq_reg       <= 1'b0;
			ext_irq_level_reg <= 3'h0;
			wake_reg          <= 1'b0;
		end else begin
			irq_in_d_reg <= pad_in[4];
			// Set wins over clear
			if (irq_hit) begin
				ext_irq_reg <= 1'b1;
			end else if (ext_irq_clear) begin
				ext_irq_reg <= 1'b0;
			end
			ext_irq_level_reg <= `PMBS_IRQ_LEVEL;
			wake_reg          <= irq_hit;
		end
	end

endmodule

/* File: verif/pmbs_pin_mux_sva.sv */
`timescale 1ns/1ns
`include "pmbs_defines.vh"

// ****************************************
// Pin mux and strap checker
// ****************************************
module pmbs_pin_mux_sva (
	// Clock and reset
	input wire        clk,
	input wire        reset,
	// Mux and pads
	input wire [19:0] mux_sel,
	input wire [9:0]  pad_in,
	input wire [9:0]  pad_oe_reg,
	// Reset pin
	input wire        reset_n_pin_out_reg,
	input wire        reset_n_pin_oe_reg,
	input wire        reset_pin_bidir_en,
	// Straps
	input wire        strap_done_reg,
	input wire        background_debug_state_reg,
	input wire        slave_spi_mode_reg,
	// Interrupt
	input wire [1:0]  ext_irq_trigger,
	input wire        ext_irq_clear,
	input wire        ext_irq_reg,
	input wire [2:0]  ext_irq_level_reg,
	input wire        wake_reg,
	// Slave select and analog
	input wire        spi_select_n_reg,
	input wire        adc_diff_en_reg
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Edge modes need a clean previous sample, hence the reset guard
	sequence s_hit;
		strap_done_reg && !$past(reset) && mux_sel[9:8] == `PMBS_SEL_FN2 &&
			(ext_irq_trigger == `PMBS_TRIG_RISE && $rose(pad_in[4]) ||
			ext_irq_trigger == `PMBS_TRIG_FALL && $fell(pad_in[4]));
	endsequence
	sequence s_release;
		$fell(reset);
	endsequence
	a_oe_before_strap: assert property (!strap_done_reg |-> pad_oe_reg == 10'h0)
		else $error("pad driven before straps sampled");
	a_strap_in_time: assert property (s_release |-> ##[1:4] strap_done_reg)
		else $error("strap sampling late");
	a_strap_held: assert property (strap_done_reg && $past(strap_done_reg) |->
		strap_done_reg && $stable({background_debug_state_reg, slave_spi_mode_reg}))
		else $error("strap result changed");
	a_reset_pin_low: assert property (reset_n_pin_oe_reg |-> !reset_n_pin_out_reg)
		else $error("reset pin driven high");
	a_reset_pin_en: assert property (!$past(reset_pin_bidir_en) |-> !reset_n_pin_oe_reg)
		else $error("reset pin driven while input only");
	a_irq_level: assert property (!$past(reset) |-> ext_irq_level_reg == `PMBS_IRQ_LEVEL)
		else $error("interrupt level wrong");
	a_irq_sticky: assert property (ext_irq_reg && !ext_irq_clear |=> ext_irq_reg)
		else $error("interrupt lost without clear");
	a_irq_edge_hit: assert property (s_hit |=> wake_reg && ext_irq_reg)
		else $error("edge trigger missed");
	a_irq_masked: assert property (mux_sel[9:8] != `PMBS_SEL_FN2 |=> !wake_reg)
		else $error("wake from unselected pin");
	a_irq_pin_off: assert property (mux_sel[9:8] == `PMBS_SEL_FN2 |=> !pad_oe_reg[4])
		else $error("interrupt pin driven");
	a_spi_sel_idle: assert property (mux_sel[7:6] != `PMBS_SEL_FN3 |=> spi_select_n_reg)
		else $error("slave select active while unrouted");
	a_adc_routed: assert property (mux_sel[15:12] == 4'h5 |=> adc_diff_en_reg)
		else $error("analog pair not routed");
endmodule

bind pmbs_pin_mux pmbs_pin_mux_sva u_sva (.clk, .reset, .mux_sel, .pad_in, .pad_oe_reg,
	.reset_n_pin_out_reg, .reset_n_pin_oe_reg, .reset_pin_bidir_en, .strap_done_reg,
	.background_debug_state_reg, .slave_spi_mode_reg, .ext_irq_trigger, .ext_irq_clear,
	.ext_irq_reg, .ext_irq_level_reg, .wake_reg, .spi_select_n_reg, .adc_diff_en_reg);

/* File: verif/pmbs_board_model.sv */
`timescale 1ns/1ns

// ****************************************
// Board straps, host and pad wires
// ****************************************
module pmbs_board_model (
	// Pads
	input  wire [9:0] pad_out_reg,
	input  wire [9:0] pad_oe_reg,
	input  wire [9:0] ext_val,
	output wire [9:0] pad_in,
	// Straps
	input  wire       strap_dbg,
	input  wire       strap_sel,
	// Reset pin
	input  wire       reset_n_pin_out_reg,
	input  wire       reset_n_pin_oe_reg,
	input  wire       host_pull,
	output wire       reset_n_pin_in
);
	// Strap resistors only show while nothing drives pins 3 and 9
	wire [9:0] far = {strap_dbg, ext_val[8:4], strap_sel, ext_val[2:0]};
	assign pad_in = (pad_oe_reg & pad_out_reg) | (~pad_oe_reg & far);
	// Pull-up wins unless someone sinks; host stays off during boot
	assign reset_n_pin_in = ~(reset_n_pin_oe_reg & ~reset_n_pin_out_reg) & ~host_pull;
endmodule

/* File: verif/pmbs_pin_mux_tb.sv */
`timescale 1ns/1ns
`include "pmbs_defines.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end

// ****************************************
// Pin mux testbench
// ****************************************
module pmbs_pin_mux_tb;
	reg         clk = 0;
	reg         reset = 1;
	reg  [19:0] mux_sel = 20'h0;
	reg         io_op_valid = 0;
	reg  [1:0]  io_op_code = 2'h0;
	reg  [15:0] io_op_data = 16'h0;
	reg  [9:0]  io_dir = 10'h3ff;
	reg  [1:0]  ext_irq_trigger = 2'h0;
	reg         reset_pin_bidir_en = 0, ext_reset_req = 0, host_pull = 0;
	reg         strap_dbg = 1, strap_sel = 1, ext_irq_clear = 0, irq_pin = 0;
	reg         master_i2c_clock_oe = 0, delay_block_out_a = 0;
	reg  [31:0] rnd = 32'h0;
	reg  [15:0] port_m = 16'h0;
	reg  [31:0] rsave = 32'h0;
	reg  [9:0]  psave = 10'h0;
	integer     seed = 32'hbb16, n_fail = 0, n_tests = 0, i;
	wire [15:0] io_read_reg;
	wire [9:0]  pad_in, pad_out_reg, pad_oe_reg;
	wire [9:0]  ext_val = {rnd[31:27], irq_pin, rnd[26:23]};
	wire        reset_n_pin_in, reset_n_pin_out_reg, reset_n_pin_oe_reg, ext_reset_detect_reg;
	wire        strap_done_reg, background_debug_state_reg, slave_spi_mode_reg;
	wire        ext_irq_reg, adc_diff_en_reg;
	wire        dbg_in_reg, slave_i2c_clock_reg, slave_i2c_data_reg, spi_clock_reg;
	wire        spi_data_in_reg, spi_select_n_reg, master_i2c_clock_reg, master_i2c_data_reg;
	wire        wake_reg, timer_channel_zero_in_reg, timer_channel_one_in_reg, adc_convert_reg;
	wire [2:0]  ext_irq_level_reg;

	always #2 clk = ~clk;
	// Side inputs not steered by a test toggle freely
	always @(posedge clk) #1 rnd <= $random(seed);

	pmbs_pin_mux DUT (.clk, .reset, .mux_sel, .io_op_valid, .io_op_code, .io_op_data, .io_dir,
		.io_read_reg, .pad_in, .pad_out_reg, .pad_oe_reg, .reset_n_pin_in, .reset_n_pin_out_reg,
		.reset_n_pin_oe_reg, .reset_pin_bidir_en, .ext_reset_req, .ext_reset_detect_reg,
		.strap_done_reg, .background_debug_state_reg, .slave_spi_mode_reg, .dbg_out(rnd[0]),
		.dbg_oe(rnd[1]), .dbg_in_reg, .slave_i2c_clock_oe(rnd[2]), .slave_i2c_data_oe(rnd[3]),
		.slave_i2c_clock_reg, .slave_i2c_data_reg, .spi_data_out(rnd[4]),
		.spi_data_out_en(rnd[5]), .spi_clock_reg, .spi_data_in_reg, .spi_select_n_reg,
		.master_i2c_clock_oe, .master_i2c_data_oe(rnd[6]), .master_i2c_clock_reg,
		.master_i2c_data_reg, .ext_irq_trigger, .ext_irq_clear, .ext_irq_reg,
		.ext_irq_level_reg, .wake_reg, .response_ready(rnd[7]), .delay_block_out_a,
		.delay_block_out_b(rnd[8]), .timer_channel_zero_out(rnd[9]),
		.timer_channel_zero_oe(rnd[10]), .timer_channel_one_out(rnd[11]),
		.timer_channel_one_oe(rnd[12]), .timer_channel_zero_in_reg,
		.timer_channel_one_in_reg, .adc_diff_en_reg, .sample_strobe(rnd[13]),
		.adc_convert_reg);

	pmbs_board_model u_board (.pad_out_reg, .pad_oe_reg, .ext_val, .pad_in, .strap_dbg,
		.strap_sel, .reset_n_pin_out_reg, .reset_n_pin_oe_reg, .host_pull, .reset_n_pin_in);

	task tick(input integer n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	function [15:0] io_next(input [15:0] p, input [1:0] c, input [15:0] d);
		case (c)
			`PMBS_OP_WRITE: io_next = d;
			`PMBS_OP_SET:   io_next = p | d;
			`PMBS_OP_CLEAR: io_next = p & ~d;
			default:        io_next = p ^ d;
		endcase
	endfunction

	task finish_test;
		$display("Checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		#20000;
		n_fail++;
		finish_test;
	end

	initial begin
		// Every strap pair, each through a fresh reset
		for (i = 0; i < 4; i++) begin
			{strap_dbg, strap_sel} = i[1:0];
			reset = 1;
			tick(4);
			reset = 0;
			`CHK("boot_oe", 10'h0, pad_oe_reg)
			tick(8);
			`CHK("debug_state", ~strap_dbg, background_debug_state_reg)
			`CHK("spi_mode", ~strap_sel, slave_spi_mode_reg)
		end
		$display("strap test done");
		// Back-to-back ops in bursts of four, all codes first
		for (i = 0; i < 24; i++) begin
			io_op_valid = 1;
			rsave = $random(seed);
			io_op_code = (i < 4) ? i[1:0] : rsave[1:0];
			rsave = $random(seed);
			io_op_data = (i == 0) ? 16'hffff : rsave[15:0];
			port_m = io_next(port_m, io_op_code, io_op_data);
			tick(1);
			if (i % 4 == 3) begin
				io_op_valid = 0;
				tick(2);
				`CHK("io_high", port_m[15:10], io_read_reg[15:10])
				`CHK("io_pads", port_m[8:2], pad_out_reg[8:2])
				`CHK("io_oe", 7'h7f, pad_oe_reg[8:2])
			end
		end
		$display("fast io test done");
		// Alternates win over fast io even with every direction bit set
		mux_sel = 20'h05510;
		for (i = 0; i < 2; i++) begin
			master_i2c_clock_oe = i[0];
			delay_block_out_a = ~i[0];
			tick(2);
			`CHK("master_oe", i[0], pad_oe_reg[2])
			`CHK("delay_pad", {1'b1, ~i[0]}, {pad_oe_reg[5], pad_out_reg[5]})
			`CHK("input_oe", 3'h0, {pad_oe_reg[7:6], pad_oe_reg[4]})
			`CHK("adc_en", 1'b1, adc_diff_en_reg)
		end
		$display("mux test done");
		for (i = 0; i < 4; i++) begin
			ext_irq_trigger = i[1:0];
			irq_pin = i[0];
			tick(2);
			ext_irq_clear = 1;
			tick(1);
			ext_irq_clear = 0;
			tick(1);
			`CHK("irq_idle", 1'b0, ext_irq_reg)
			irq_pin = ~i[0];
			tick(2);
			`CHK("irq_hit", 1'b1, ext_irq_reg)
		end
		ext_irq_trigger = `PMBS_TRIG_RISE;
		irq_pin = 0;
		io_dir = 10'h0;
		tick(2);
		ext_irq_clear = 1;
		mux_sel = 20'h0;
		tick(1);
		ext_irq_clear = 0;
		irq_pin = 1;
		tick(2);
		`CHK("irq_masked", 1'b0, ext_irq_reg)
		$display("irq test done");
		reset_pin_bidir_en = 1;
		ext_reset_req = 1;
		tick(2);
		`CHK("rst_drive", 3'h4, {reset_n_pin_oe_reg, reset_n_pin_in, ext_reset_detect_reg})
		reset_pin_bidir_en = 0;
		tick(2);
		`CHK("rst_input", 1'b0, reset_n_pin_oe_reg)
		host_pull = 1;
		tick(2);
		`CHK("rst_detect", 1'b1, ext_reset_detect_reg)
		host_pull = 0;
		$display("reset pin test done");
		// Debug boot; pin 9 goes to the debug port, alternates on pins 4 to 7
		strap_dbg = 0;
		reset = 1;
		tick(4);
		reset = 0;
		tick(8);
		`CHK("debug_boot", 1'b1, background_debug_state_reg)
		mux_sel = 20'h0a900;
		tick(2);
		for (i = 0; i < 8; i++) begin
			// Sample random side inputs once they have settled
			#1;
			rsave = rnd;
			psave = pad_in;
			tick(1);
			`CHK("dbg_pad", rsave[1:0], {pad_oe_reg[9], pad_out_reg[9]})
			`CHK("resp_pad", {1'b1, rsave[7]}, {pad_oe_reg[5], pad_out_reg[5]})
			`CHK("timer_pads", {rsave[12:9]}, {pad_oe_reg[7], pad_out_reg[7], pad_oe_reg[6], pad_out_reg[6]})
			`CHK("timer_in", psave[7:6], {timer_channel_one_in_reg, timer_channel_zero_in_reg})
			`CHK("slave_mirror", {psave[1:0], psave[1:0]}, {slave_i2c_data_reg, slave_i2c_clock_reg, spi_data_in_reg, spi_clock_reg})
			`CHK("master_mirror", psave[3:2], {master_i2c_data_reg, master_i2c_clock_reg})
			`CHK("dbg_in", psave[9], dbg_in_reg)
			`CHK("spi_sel_idle", 1'b1, spi_select_n_reg)
			`CHK("adc_idle", 1'b0, adc_convert_reg)
			`CHK("irq_level", `PMBS_IRQ_LEVEL, ext_irq_level_reg)
		end
		ext_irq_trigger = `PMBS_TRIG_RISE;
		irq_pin = 0;
		tick(2);
		irq_pin = 1;
		tick(1);
		`CHK("wake_hit", 1'b1, wake_reg)
		tick(1);
		`CHK("wake_pulse", 1'b0, wake_reg)
		$display("debug and alternate test done");
		finish_test;
	end
endmodule
